// File: inc/svab_consts.svh
/*
 constants for the spurious-vector host controller and its message-bus arbiter.
 assumes it is included by bare name from the package and the logic file.
*/
`ifndef SVAB_CONSTS_SVH
`define SVAB_CONSTS_SVH
`define SVAB_VEC_W      8
`define SVAB_PRI_W      4
`define SVAB_PRI_MAX    4'hf
`define SVAB_PRI_ZERO   4'h0
`define SVAB_PRI_ONE    4'h1
`define SVAB_LOW_ONES   4'hf
`define SVAB_SVEC_RST   8'hff
`define SVAB_CFG_ENA    8
`define SVAB_CFG_FOCUS  9
`define SVAB_ARB_CYC    5
`define SVAB_SLOT       3
`define SVAB_CNT_W      3
`endif

// File: inc/svab_pkg.sv
/*
 types for the spurious-vector host controller.
 assumes svab_consts.svh sits on the include path.
*/
`include "svab_consts.svh"
package svab_pkg;
	typedef enum logic [3:0]
	{
		SVAB_IDLE = 4'b0001,
		SVAB_ARB  = 4'b0010,
		SVAB_SEND = 4'b0100,
		SVAB_LOST = 4'b1000
	} svab_state_e;

	typedef struct packed
	{
		logic       isEoi;
		logic [3:0] pri;
	} svab_arb_s;
endpackage

// File: logic/svab_host.sv
/*
 host side: drives the spurious-vector register image of the device, answers
 acknowledge cycles for it, and contends on the shared message bus.
 assumes open-drain bus wired-and (low wins) resolved outside; the bus pin
 arrives unsynced and is synchronised here.
*/
`include "svab_consts.svh"
module svab_host
	import svab_pkg::*;
#(
	parameter bit         LEGACY   = 1'b0,
	parameter logic [3:0] ARB_INIT = 4'h0
)
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        cfgWr,
	input  wire logic [31:0] cfgWdata,
	output logic      [31:0] cfgRdata,
	input  wire logic        ackCycle,
	input  wire logic        reqMasked,
	input  wire logic [7:0]  reqVector,
	output logic             ackValid,
	output logic      [7:0]  ackVector,
	output logic             ackSpurious,
	input  wire logic        eoiWr,
	input  wire logic [7:0]  inServiceTop,
	output logic             inServiceClear,
	output logic             ctrlEnable,
	output logic             focusCheckOn,
	input  wire logic        sendReq,
	input  wire logic        sendEoi,
	input  wire logic        msgDone,
	output logic             sendBusy,
	output logic             sendWon,
	input  wire logic        busIn,
	output logic             busOut,
	output logic             busOe,
	output logic      [3:0]  arbPri,
	input  wire logic [7:0]  lowPriSelf,
	input  wire logic [7:0]  lowPriPeer,
	input  wire logic [3:0]  tieIdPeer,
	output logic             lowPriAccept
);
	initial
	begin
		if (`SVAB_PRI_W != 4)
			$error("arbitration priority must be four bits");
	end

	// ----------------------------------------------------------------------
	// register image
	// ----------------------------------------------------------------------
	logic [7:0] svec_q;
	logic       ena_q;
	logic       focus_q;
	wire  [7:0] svecWr = LEGACY ? {cfgWdata[7:4], `SVAB_LOW_ONES} : cfgWdata[7:0];
	wire        focusWr = LEGACY ? cfgWdata[`SVAB_CFG_FOCUS] : 1'b0;

	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			svec_q  <= `SVAB_SVEC_RST;
			ena_q   <= 1'b0;
			focus_q <= 1'b0;
		end
		else if (cfgWr)
		begin
			svec_q  <= svecWr;
			ena_q   <= cfgWdata[`SVAB_CFG_ENA];
			focus_q <= focusWr;
		end

	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			cfgRdata     <= 32'h0000_0000;
			ctrlEnable   <= 1'b0;
			focusCheckOn <= 1'b0;
		end
		else
		begin
			cfgRdata     <= {22'h00_0000, focus_q, ena_q, svec_q};
			ctrlEnable   <= ena_q;
			focusCheckOn <= ~focus_q;
		end

	// ----------------------------------------------------------------------
	// acknowledge and end-of-interrupt
	// ----------------------------------------------------------------------
	// spurious answer never touches in-service bits, so no clear request
	wire spur = reqMasked;
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			ackValid       <= 1'b0;
			ackVector      <= 8'h00;
			ackSpurious    <= 1'b0;
			inServiceClear <= 1'b0;
		end
		else
		begin
			ackValid       <= ackCycle & ena_q;
			ackVector      <= spur ? svec_q : reqVector;
			ackSpurious    <= ackCycle & ena_q & spur;
			// a spurious-vector in-service bit is cleared only by a real eoi
			inServiceClear <= eoiWr & ena_q;
		end

	// ----------------------------------------------------------------------
	// message bus arbitration
	// ----------------------------------------------------------------------
	logic        b1_q;
	logic        b2_q;
	svab_state_e state_q;
	logic [2:0]  cyc_q;
	logic [3:0]  pri_q;
	logic [3:0]  winPri_q;
	logic [4:0]  word_q;
	logic [1:0]  ph_q;
	// eoi flag leads, so a lone eoi wins; a one bit drives the bus low
	wire  [4:0]  myWord = {sendEoi, pri_q};

	function automatic logic [3:0] incPri(input logic [3:0] p);
		return p + `SVAB_PRI_ONE;
	endfunction

	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			b1_q <= 1'b1;
			b2_q <= 1'b1;
		end
		else
		begin
			b1_q <= busIn;
			b2_q <= b1_q;
		end

	// each bit is held a full slot: the two-stage sync needs that long to see it
	wire slotEnd = ph_q == 2'(`SVAB_SLOT - 1);
	wire myBit   = word_q[`SVAB_ARB_CYC - 1];
	wire lostBit = slotEnd & ~myBit & ~b2_q;
	wire arbEnd  = slotEnd & (cyc_q == 3'(`SVAB_ARB_CYC - 1));
	wire bitsLeft = cyc_q != 3'(`SVAB_ARB_CYC);
	// winner value seen on the bus is rebuilt from observed bits
	logic [4:0] seen_q;

	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			state_q  <= SVAB_IDLE;
			cyc_q    <= 3'h0;
			ph_q     <= 2'h0;
			pri_q    <= ARB_INIT;
			winPri_q <= `SVAB_PRI_ZERO;
			word_q   <= 5'h00;
			seen_q   <= 5'h00;
			busOut   <= 1'b1;
			busOe    <= 1'b0;
			sendBusy <= 1'b0;
			sendWon  <= 1'b0;
		end
		else
		begin
			sendWon <= 1'b0;
			case (state_q)
				SVAB_IDLE:
				begin
					if (sendReq & ena_q)
					begin
						state_q  <= SVAB_ARB;
						word_q   <= myWord;
						cyc_q    <= 3'h0;
						ph_q     <= 2'h0;
						busOe    <= myWord[`SVAB_ARB_CYC - 1];
						busOut   <= 1'b0;
						sendBusy <= 1'b1;
					end
					else if (msgDone)
						pri_q <= (pri_q == `SVAB_PRI_MAX) ? incPri(winPri_q) : incPri(pri_q);
				end
				SVAB_ARB:
				begin
					ph_q <= slotEnd ? 2'h0 : ph_q + 2'h1;
					if (slotEnd)
					begin
						seen_q <= {seen_q[3:0], ~b2_q};
						word_q <= {word_q[3:0], 1'b0};
						cyc_q  <= cyc_q + 3'h1;
						if (lostBit)
						begin
							state_q <= SVAB_LOST;
							busOe   <= 1'b0;
						end
						else if (arbEnd)
							state_q <= SVAB_SEND;
						else
							busOe <= word_q[`SVAB_ARB_CYC - 2];
					end
				end
				SVAB_SEND:
				begin
					busOe <= 1'b0; // payload drive left to message logic
					if (msgDone)
					begin
						winPri_q <= pri_q;
						pri_q    <= `SVAB_PRI_ZERO;
						state_q  <= SVAB_IDLE;
						sendBusy <= 1'b0;
						sendWon  <= 1'b1;
					end
				end
				SVAB_LOST:
				begin
					// keep watching the remaining bits to learn the winner priority
					if (bitsLeft)
					begin
						ph_q <= slotEnd ? 2'h0 : ph_q + 2'h1;
						if (slotEnd)
						begin
							seen_q <= {seen_q[3:0], ~b2_q};
							cyc_q  <= cyc_q + 3'h1;
						end
					end
					if (msgDone)
					begin
						// winner priority taken from the bits it drove
						winPri_q <= seen_q[3:0];
						pri_q    <= (pri_q == `SVAB_PRI_MAX) ? incPri(seen_q[3:0]) :
							incPri(pri_q);
						state_q  <= SVAB_IDLE;
						sendBusy <= 1'b0;
					end
				end
				default:
					state_q <= SVAB_IDLE;
			endcase
		end

	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			arbPri       <= 4'h0;
			lowPriAccept <= 1'b0;
		end
		else
		begin
			arbPri       <= pri_q;
			lowPriAccept <= (lowPriSelf < lowPriPeer) ||
				((lowPriSelf == lowPriPeer) && (pri_q > tieIdPeer));
		end

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	property p_spur;
		@(posedge sys_clk) disable iff (!nrst)
		ackCycle && ena_q && reqMasked |=> ackVector == $past(svec_q);
	endproperty
	a_spur: assert property (p_spur) else $error("spurious vector not returned");

	property p_noclr;
		@(posedge sys_clk) disable iff (!nrst)
		ackCycle && !eoiWr |=> !inServiceClear;
	endproperty
	a_noclr: assert property (p_noclr) else $error("acknowledge cleared in-service");

	property p_legacy;
		@(posedge sys_clk) disable iff (!nrst)
		LEGACY |-> svec_q[3:0] == `SVAB_LOW_ONES;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy low bits not ones");

	property p_wr;
		@(posedge sys_clk) disable iff (!nrst)
		cfgWr && !LEGACY |=> ##1 cfgRdata[7:0] == $past(cfgWdata[7:0], 2);
	endproperty
	a_wr: assert property (p_wr) else $error("vector readback differs");

	property p_ena;
		@(posedge sys_clk) disable iff (!nrst)
		cfgWr |=> ##1 ctrlEnable == $past(cfgWdata[`SVAB_CFG_ENA], 2);
	endproperty
	a_ena: assert property (p_ena) else $error("enable bit not applied");

	property p_lose;
		@(posedge sys_clk) disable iff (!nrst)
		state_q == SVAB_ARB && lostBit |=> !busOe;
	endproperty
	a_lose: assert property (p_lose) else $error("loser kept driving");

	property p_win;
		@(posedge sys_clk) disable iff (!nrst)
		state_q == SVAB_SEND && msgDone |=> pri_q == `SVAB_PRI_ZERO && sendWon;
	endproperty
	a_win: assert property (p_win) else $error("winner priority not zero");

	property p_inc;
		@(posedge sys_clk) disable iff (!nrst)
		state_q == SVAB_IDLE && !sendReq && msgDone && pri_q != `SVAB_PRI_MAX
			|=> pri_q == $past(pri_q) + `SVAB_PRI_ONE;
	endproperty
	a_inc: assert property (p_inc) else $error("priority not advanced");

	property p_eoi;
		@(posedge sys_clk) disable iff (!nrst)
		eoiWr && ena_q |=> inServiceClear;
	endproperty
	a_eoi: assert property (p_eoi) else $error("eoi did not clear");
endmodule // svab_host

// File: testbench/svab_peer_model.sv
/*
 behavioural peer controller on the shared message bus.
 assumes an open-drain bus with pull-up, resolved by the bench.
*/
module svab_peer_model
	import svab_pkg::*;
#(
	parameter logic [3:0] PRI_INIT = 4'h5
)
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic       isEoi,
	input  wire logic       msgDone,
	input  wire logic       busLine,
	output logic            busOe,
	output logic      [3:0] pri
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] arb;
	logic [3:0] winPri;
	logic       won;
	logic       active;
	logic       stay;
	int         idx;
	int         ph;
	// -----------------
	// arbitration
	// -----------------
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pri <= PRI_INIT;
			busOe <= 1'b0;
			active <= 1'b0;
			won <= 1'b0;
			winPri <= 4'h0;
			idx <= -1;
			ph <= 0;
		end
		else if (msgDone)
		begin
			active <= 1'b0;
			busOe <= 1'b0;
			idx <= -1;
			if (active && won)
				pri <= 4'h0;
			else if (pri == 4'hf)
				pri <= winPri + 4'h1;
			else
				pri <= pri + 4'h1;
		end
		else if (start)
		begin
			arb <= {isEoi, pri};
			active <= 1'b1;
			won <= 1'b1;
			idx <= 4;
			ph <= 0;
			busOe <= isEoi;
		end
		else if (active && idx >= 0)
		begin
			if (ph == 2)
			begin
				ph <= 0;
				if (idx < 4)
					winPri[idx] <= ~busLine;
				stay = won && !(!arb[idx] && !busLine);
				won <= stay;
				busOe <= stay && (idx == 0 || arb[idx-1]);
				idx <= idx - 1;
			end
			else
				ph <= ph + 1;
		end
		else if (active)
			busOe <= won && !busOe; // payload varies each cycle
	end
endmodule // svab_peer_model

// File: testbench/svab_host_bench.sv
/*
 self-checking bench for svab_host with one bus peer.
 assumes the peer model and package are compiled first.
*/
module svab_host_bench
	import svab_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cfgWr, ackCycle, reqMasked, eoiWr, sendReq, sendEoi, msgDone;
	logic        peerStart, peerEoi;
	logic [31:0] cfgWdata, cfgRdata, legRdata;
	logic [7:0]  reqVector, ackVector, lowPriSelf, lowPriPeer;
	logic [3:0]  tieIdPeer, arbPri, peerPri;
	logic [7:0]  inServiceTop;
	logic        ackValid, ackSpurious, inServiceClear, ctrlEnable, focusCheckOn, legFocus;
	logic        sendBusy, sendWon, busOut, busOe, peerOe, lowPriAccept;
	wire         busLine = ~(busOe | peerOe);
	int          n_mismatch = 0;
	int          checks = 0;
	// -----------------
	// instances
	// -----------------
	svab_host #(.LEGACY(1'b0), .ARB_INIT(4'h3)) svab_host_i (.sys_clk, .nrst, .cfgWr,
		.cfgWdata, .cfgRdata, .ackCycle, .reqMasked, .reqVector, .ackValid, .ackVector,
		.ackSpurious, .eoiWr, .inServiceTop, .inServiceClear, .ctrlEnable,
		.focusCheckOn, .sendReq, .sendEoi, .msgDone, .sendBusy, .sendWon,
		.busIn(busLine), .busOut, .busOe, .arbPri, .lowPriSelf, .lowPriPeer,
		.tieIdPeer, .lowPriAccept);
	// legacy copy sees config and acknowledge traffic but never contends
	svab_host #(.LEGACY(1'b1), .ARB_INIT(4'h9)) svab_host_legacy_i (.sys_clk, .nrst,
		.cfgWr, .cfgWdata, .cfgRdata(legRdata), .ackCycle, .reqMasked,
		.reqVector, .ackValid(), .ackVector(), .ackSpurious(), .eoiWr,
		.inServiceTop, .inServiceClear(), .ctrlEnable(), .focusCheckOn(legFocus),
		.sendReq(1'b0), .sendEoi(1'b0), .msgDone, .sendBusy(), .sendWon(),
		.busIn(1'b1), .busOut(), .busOe(), .arbPri(), .lowPriSelf, .lowPriPeer,
		.tieIdPeer, .lowPriAccept());
	svab_peer_model #(.PRI_INIT(4'h5)) svab_peer_model_i (.sys_clk, .nrst,
		.start(peerStart), .isEoi(peerEoi), .msgDone, .busLine, .busOe(peerOe),
		.pri(peerPri));
	always #12.5 sys_clk = ~sys_clk;
	// -----------------
	// tasks
	// -----------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cfg(input logic [31:0] d, input logic [31:0] e, input logic [31:0] l);
		@(posedge sys_clk);
		cfgWr <= 1'b1;
		cfgWdata <= d;
		@(posedge sys_clk);
		cfgWr <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("cfgRdata", e, cfgRdata);
		chk("legRdata", l, legRdata);
		chk("ctrlEnable", d[8], ctrlEnable);
	endtask
	// one acknowledge, or one end-of-interrupt write when eoi is set
	task automatic ack(input logic end_of_interrupt, m, input logic [7:0] v, ev, input logic sp, va);
		@(posedge sys_clk);
		ackCycle <= ~end_of_interrupt;
		eoiWr <= end_of_interrupt;
		reqMasked <= m;
		reqVector <= v;
		@(posedge sys_clk);
		ackCycle <= 1'b0;
		eoiWr <= 1'b0;
		#1;
		chk("ackValid", va, ackValid);
		chk("inServiceClear", end_of_interrupt, inServiceClear);
		if (va && !end_of_interrupt)
		begin
			chk("ackVector", ev, ackVector);
			chk("ackSpurious", sp, ackSpurious);
		end
	endtask
	task automatic lp(input logic [7:0] s, p, input logic [3:0] t, input logic e);
		@(posedge sys_clk);
		lowPriSelf <= s;
		lowPriPeer <= p;
		tieIdPeer <= t;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("lowPriAccept", e, lowPriAccept);
	endtask
	task automatic send(input logic eo, pg, pe, w, input logic [3:0] ep, epp);
		@(posedge sys_clk);
		sendReq <= 1'b1;
		sendEoi <= eo;
		peerStart <= pg;
		peerEoi <= pe;
		@(posedge sys_clk);
		sendReq <= 1'b0;
		peerStart <= 1'b0;
		repeat (20) @(posedge sys_clk);
		msgDone <= 1'b1;
		@(posedge sys_clk);
		msgDone <= 1'b0;
		sendEoi <= 1'b0;
		#1;
		chk("sendWon", w, sendWon);
		@(posedge sys_clk);
		#1;
		chk("arbPri", ep, arbPri);
		chk("peerPri", epp, peerPri);
	endtask
	// -----------------
	// sequence
	// -----------------
	initial
	begin
		{cfgWr, ackCycle, reqMasked, eoiWr, sendReq, sendEoi, msgDone} = 7'h00;
		{peerStart, peerEoi, cfgWdata, reqVector} = '0;
		{lowPriSelf, lowPriPeer, tieIdPeer, inServiceTop} = '0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk("arbPri", 4'h3, arbPri);
		ack(1'b0, 1'b1, 8'h31, 8'h00, 1'b0, 1'b0);
		cfg(32'h0000015a, 32'h0000015a, 32'h0000015f);
		chk("focusCheckOn", 1'b1, focusCheckOn);
		cfg(32'h000003a5, 32'h000001a5, 32'h000003af);
		chk("legFocus", 1'b0, legFocus);
		ack(1'b0, 1'b1, 8'h31, 8'ha5, 1'b1, 1'b1);
		ack(1'b0, 1'b0, 8'h31, 8'h31, 1'b0, 1'b1);
		ack(1'b1, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
		lp(8'h41, 8'h42, 4'h2, 1'b1);
		lp(8'h42, 8'h41, 4'h2, 1'b0);
		lp(8'h41, 8'h41, 4'h2, 1'b1);
		lp(8'h41, 8'h41, 4'h5, 1'b0);
		send(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h6);
		send(1'b0, 1'b1, 1'b0, 1'b0, 4'h1, 4'h0);
		send(1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 4'h1);
		send(1'b1, 1'b1, 1'b1, 1'b0, 4'h1, 4'h0);
		wrap_up();
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		wrap_up();
	end
endmodule // svab_host_bench
